/* File: pmw_cfg.svh */
// Constants for the power mode and wake control block
`ifndef PMW_CFG_SVH
`define PMW_CFG_SVH
`define PMW_MODE_W 3
`define PMW_RST_RUN 1'b0
`define PMW_SYNC_W 2
`define PMW_PERIPH_OFF 4'h0
`define PMW_RETAIN_ALL 3'h7
`endif

/* File: pmw_pkg.sv */
// Types for the power mode and wake control block
package pmw_pkg;
    // Target configurations, encodings are the request code
    typedef enum logic [2:0] {
        PMW_RUN = 3'h0,
        PMW_RPR = 3'h1,
        PMW_WAIT = 3'h2,
        PMW_RPW = 3'h3,
        PMW_STOP = 3'h4,
        PMW_RPS = 3'h5,
        PMW_LLS = 3'h6,
        PMW_LWS = 3'h7
    } pmw_mode_t;
    // Which wake controller serves a mode
    typedef enum logic [1:0] {
        PMW_WK_NONE = 2'h0,
        PMW_WK_NESTED = 2'h1,
        PMW_WK_ASYNC = 2'h2,
        PMW_WK_LEAK = 2'h3
    } pmw_wake_t;
endpackage

/* File: pmw_sync.sv */
// Two flip-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/100ps
`default_nettype none
module pmw_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r; // First stage, read only by the second
    // Two stages, held while the clock enable is low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else if (ce) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // pmw_sync
`default_nettype wire

/* File: pmw_ctrl.sv */
// Power mode controller: module enables and wake routing per configuration
`timescale 1ns/100ps
`default_nettype none
`include "pmw_cfg.svh"
// Notes on behaviour
// - Both run modes: core on, all peripherals reachable
// - Normal run: every module operational
// - Reduced run: slow clock, droop monitor off
// - Normal wait: core sleeps, peripherals run
// - Reduced wait: core sleeps, slow, monitor off
// - Enabled peripherals keep running during wait
// - Deep sleep: core and all peripherals off
// - Deep sleep: retention chosen by application
// - Wait wake comes from nested controller
// - Stop wake comes from async controller
// - Leakage stops wake via leakage wake unit
module pmw_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic mode_req_valid,
    input wire logic [`PMW_MODE_W-1:0] mode_req,
    input wire logic sleep_entry,
    input wire logic [2:0] retain_cfg,
    input wire logic [3:0] periph_en,
    input wire logic nested_irq_wake,
    input wire logic async_wake_irq,
    input wire logic leak_wake_evt,
    output logic [`PMW_MODE_W-1:0] cur_mode,
    output logic core_active,
    output logic core_sleep,
    output logic clk_reduced,
    output logic [3:0] periph_run,
    output logic supply_droop_monitor_en,
    output logic [2:0] retain_en,
    output logic [1:0] wake_src,
    output logic wake_pulse
);
    logic [`PMW_MODE_W-1:0] target_r; // Latched requested configuration
    logic run_slow_r; // Run flavour active before entry
    pmw_pkg::pmw_mode_t mode_r; // Present configuration
    pmw_pkg::pmw_mode_t mode_nxt; // Configuration after this edge
    logic [1:0] wake_src_r; // Controller that served the last wake
    logic wake_pulse_r; // High for the cycle the mode returns to run
    logic [2:0] wk_sync; // Synchronised asynchronous wake lines
    // Wake lines come from other clock domains
    pmw_sync #(.W(3)) u_wk_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .d({leak_wake_evt, async_wake_irq, nested_irq_wake}),
        .q(wk_sync)
    );
    // Mode class decoding
    function automatic pmw_pkg::pmw_wake_t wake_of(input pmw_pkg::pmw_mode_t m);
        case (m)
            pmw_pkg::PMW_WAIT, pmw_pkg::PMW_RPW: wake_of = pmw_pkg::PMW_WK_NESTED;
            pmw_pkg::PMW_STOP, pmw_pkg::PMW_RPS: wake_of = pmw_pkg::PMW_WK_ASYNC;
            pmw_pkg::PMW_LLS, pmw_pkg::PMW_LWS: wake_of = pmw_pkg::PMW_WK_LEAK;
            default: wake_of = pmw_pkg::PMW_WK_NONE;
        endcase
    endfunction
    // Wake class of the present mode doubles as its mode class
    wire pmw_pkg::pmw_wake_t cls = wake_of(mode_r);
    // Run flavours have no wake controller
    wire is_run = (cls == pmw_pkg::PMW_WK_NONE);
    // Wait flavours are served by the nested controller
    wire is_wait = (cls == pmw_pkg::PMW_WK_NESTED);
    // Both stop classes share the upper class bit
    wire is_deep = cls[1];
    // Reduced clock flavours of run and wait
    wire slow = (mode_r == pmw_pkg::PMW_RPR) || (mode_r == pmw_pkg::PMW_RPW);
    // Wake from the controller that serves the present mode only
    wire wake_hit = (is_wait && wk_sync[0]) || (cls == pmw_pkg::PMW_WK_ASYNC && wk_sync[1]) ||
        (cls == pmw_pkg::PMW_WK_LEAK && wk_sync[2]);
    // Latched target and the run flavour to resume, as mode values
    wire pmw_pkg::pmw_mode_t tgt = pmw_pkg::pmw_mode_t'(target_r);
    wire pmw_pkg::pmw_mode_t resume = run_slow_r ? pmw_pkg::PMW_RPR : pmw_pkg::PMW_RUN;
    // Next configuration
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            pmw_pkg::PMW_RUN, pmw_pkg::PMW_RPR: begin
                // Entry takes the latched target; a run target switches flavour
                if (sleep_entry || wake_of(tgt) == pmw_pkg::PMW_WK_NONE) begin
                    mode_nxt = tgt;
                end
            end
            default: begin
                // Any wait or stop mode waits for its own wake source
                if (wake_hit) begin
                    mode_nxt = resume;
                end
            end
        endcase
    end
    // Target latch and present mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            target_r <= pmw_pkg::PMW_RUN;
            mode_r <= pmw_pkg::PMW_RUN;
            run_slow_r <= `PMW_RST_RUN;
            wake_src_r <= pmw_pkg::PMW_WK_NONE;
            wake_pulse_r <= 1'b0;
        end else if (ce) begin
            // Targets are taken only while the core runs
            if (mode_req_valid && is_run) begin
                target_r <= mode_req;
            end
            // Remember the run flavour while still running
            if (is_run) begin
                run_slow_r <= slow;
            end
            mode_r <= mode_nxt;
            // One-cycle pulse on the edge that leaves a low-power mode
            wake_pulse_r <= !is_run && wake_hit;
            if (!is_run && wake_hit) begin
                wake_src_r <= cls;
            end
        end
    end
    // Outputs per configuration
    // Present mode straight from its register
    assign cur_mode = mode_r;
    // Core runs only in the two run flavours
    assign core_active = is_run;
    // Core sleeps in every wait and stop flavour
    assign core_sleep = !is_run;
    // Reduced clock in reduced run and reduced wait
    assign clk_reduced = slow;
    // All peripherals in run, enabled ones in wait, none in deep sleep
    assign periph_run = is_run ? '1 : (is_wait ? periph_en : `PMW_PERIPH_OFF);
    // Droop monitor off whenever the clock is reduced
    assign supply_droop_monitor_en = !slow;
    // Application retention applies only in deep sleep
    assign retain_en = is_deep ? retain_cfg : `PMW_RETAIN_ALL;
    // Last wake source and its pulse, both registered
    assign wake_src = wake_src_r;
    assign wake_pulse = wake_pulse_r;
    // Checks
    // Run flavours keep the core and every peripheral on
    chk_run_core_on: assert property (@(posedge clk) disable iff (!rst_n)
        (cur_mode <= 3'h1) |-> core_active && periph_run == 4'hf)
        else $error("run core off");
    // Normal run keeps the droop monitor on
    chk_run_monitor: assert property (@(posedge clk) disable iff (!rst_n)
        (cur_mode == 3'h0) |-> supply_droop_monitor_en)
        else $error("monitor off in run");
    // Reduced flavours run slow with the monitor off
    chk_slow_monitor: assert property (@(posedge clk) disable iff (!rst_n)
        (cur_mode == 3'h1 || cur_mode == 3'h3) |-> !supply_droop_monitor_en && clk_reduced)
        else $error("reduced mode monitor on");
    // Wait flavours sleep the core and follow the software enables
    chk_wait_periph: assert property (@(posedge clk) disable iff (!rst_n)
        (cur_mode == 3'h2 || cur_mode == 3'h3) |-> core_sleep && periph_run == periph_en)
        else $error("wait peripherals wrong");
    // Deep sleep turns the core and the peripherals off
    chk_deep_off: assert property (@(posedge clk) disable iff (!rst_n)
        cur_mode[2] |-> !core_active && periph_run == 4'h0 && retain_en == retain_cfg)
        else $error("deep sleep not off");
    // Wait flavours wake only from the nested controller
    chk_wait_wake: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && wake_pulse_r && $past(cls) == pmw_pkg::PMW_WK_NESTED) |-> $past(wk_sync[0]))
        else $error("wait woke by wrong source");
    // Stop flavours wake only from the asynchronous controller
    chk_stop_wake: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && wake_pulse_r && $past(cls) == pmw_pkg::PMW_WK_ASYNC) |-> $past(wk_sync[1]))
        else $error("stop woke by wrong source");
    // Leakage stops wake only from the leakage wake unit
    chk_leak_wake: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && wake_pulse_r && $past(cls) == pmw_pkg::PMW_WK_LEAK) |-> $past(wk_sync[2]))
        else $error("leak stop woke by wrong source");
    // A wake returns to the run flavour held at entry
    chk_resume_run: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && !is_run && wake_hit) |=> (cur_mode == {2'b00, run_slow_r}))
        else $error("wake resumed wrong run");
    // Reset leaves normal run with no wake pending
    chk_reset_state: assert property (@(posedge clk)
        !rst_n |=> cur_mode == pmw_pkg::PMW_RUN && !wake_pulse && wake_src == pmw_pkg::PMW_WK_NONE)
        else $error("reset state wrong");
    // Requests made while asleep leave the target alone
    chk_refuse_req: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && !is_run) |=> target_r == $past(target_r))
        else $error("target changed while asleep");
    // Entry goes to the target latched before the strobe
    chk_entry_target: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && is_run && sleep_entry) |=> cur_mode == $past(target_r))
        else $error("entry missed the target");
    // A run target switches flavour without an entry strobe
    chk_run_switch: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && is_run && target_r[2:1] == 2'b00) |=> cur_mode == $past(target_r))
        else $error("run flavour not applied");
    // Without its own wake source a low-power mode holds
    chk_hold_sleep: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && !is_run && !wake_hit) |=> cur_mode == $past(cur_mode))
        else $error("left sleep without wake");
    // A wake records its source and raises the pulse
    chk_wake_code: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && !is_run && wake_hit) |=> wake_pulse && wake_src == $past(cls))
        else $error("wake source not recorded");
    // The wake pulse never stands for two enabled cycles
    chk_pulse_single: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && wake_pulse) |=> !wake_pulse)
        else $error("wake pulse too long");
    // Clock enable low holds the present mode, the wake pulse and the latched target
    chk_clock_freeze: assert property (@(posedge clk) disable iff (!rst_n)
        !ce |=> cur_mode == $past(cur_mode) && wake_pulse == $past(wake_pulse) && target_r == $past(target_r))
        else $error("state moved with clock enable low");
    // Outside deep sleep everything is retained
    chk_retain_awake: assert property (@(posedge clk) disable iff (!rst_n)
        !cur_mode[2] |-> retain_en == `PMW_RETAIN_ALL)
        else $error("retention dropped while awake");
    // The core is either active or asleep, never both
    chk_core_states: assert property (@(posedge clk) disable iff (!rst_n)
        core_sleep != core_active)
        else $error("core state flags clash");
    // Normal run and normal wait keep the full clock and the monitor
    chk_full_clock: assert property (@(posedge clk) disable iff (!rst_n)
        (cur_mode == 3'h0 || cur_mode == 3'h2) |-> !clk_reduced && supply_droop_monitor_en)
        else $error("full clock mode slowed");
endmodule // pmw_ctrl
`default_nettype wire

/* File: pmw_wake_model.sv */
// Behavioural model of the wake-up controllers that feed the power mode block
`timescale 1ns/100ps
`default_nettype none
module pmw_wake_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] want,
    output logic nested_irq_wake,
    output logic async_wake_irq,
    output logic leak_wake_evt
);
    // Wake levels follow the requested pattern one cycle late and are low in reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {leak_wake_evt, async_wake_irq, nested_irq_wake} <= 3'h0;
        end else begin
            {leak_wake_evt, async_wake_irq, nested_irq_wake} <= want;
        end
    end
endmodule // pmw_wake_model
`default_nettype wire

/* File: power_mode_wake_control_tb_top.sv */
// Self-checking testbench for the power mode and wake control block
`timescale 1ns/100ps
`default_nettype none
module power_mode_wake_control_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, req_v = 1'b0, sleep_entry = 1'b0; // Core side
    logic [2:0] mode_req = 3'h0, retain_cfg = 3'h0, want = 3'h0, cur_mode, retain_en, m;
    logic [3:0] periph_en = 4'h0, periph_run; // Software enables and resulting run lines
    logic nw, aw, lw, core_active, core_sleep, clk_reduced, mon_en, wake_pulse, r;
    logic [1:0] wake_src, s; // Observed and expected wake source
    logic [10:0] outs; // All per-mode enables packed for one comparison
    integer errors = 0, n_compared = 0, seed = 32'hee0a1fd9, k;
    assign outs = {core_active, core_sleep, clk_reduced, periph_run, mon_en, retain_en};
    // Clock at 200 MHz
    always #2.5 clk = ~clk;
    pmw_wake_model pmw_wake_model_inst (.clk(clk), .rst_n(rst_n), .want(want), .nested_irq_wake(nw),
        .async_wake_irq(aw), .leak_wake_evt(lw));
    pmw_ctrl pmw_ctrl_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .mode_req_valid(req_v), .mode_req(mode_req),
        .sleep_entry(sleep_entry), .retain_cfg(retain_cfg), .periph_en(periph_en), .nested_irq_wake(nw),
        .async_wake_irq(aw), .leak_wake_evt(lw), .cur_mode(cur_mode), .core_active(core_active),
        .core_sleep(core_sleep), .clk_reduced(clk_reduced), .periph_run(periph_run),
        .supply_droop_monitor_en(mon_en), .retain_en(retain_en), .wake_src(wake_src), .wake_pulse(wake_pulse));
    // Expected enables for a mode
    function automatic logic [10:0] exp_out(input logic [2:0] md);
        logic run, deep, slow;
        run = md < 3'h2;
        deep = md > 3'h3;
        slow = (md == 3'h1) || (md == 3'h3);
        exp_out = {run, !run, slow, run ? 4'hf : (deep ? 4'h0 : periph_en), !slow, deep ? retain_cfg : 3'h7};
    endfunction
    // Compare the packed enables
    task automatic cmp_out(input logic [10:0] got, input logic [10:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: enables %h, expected %h", $time, got, exp);
        end
    endtask
    // Compare a mode or wake code
    task automatic cmp_mode(input logic [2:0] got, input logic [2:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: code %h, expected %h", $time, got, exp);
        end
    endtask
    // Print the verdict and stop
    task automatic end_sim;
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Main sequence: every low-power mode first, then random ones
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        cmp_out(outs, exp_out(3'h0));
        cmp_mode({1'b0, wake_src}, 3'h0);
        for (int i = 0; i < 14; i++) begin
            r = 1'($random(seed));
            m = (i < 6) ? 3'(i + 2) : 3'h2 + 3'($unsigned($random(seed)) % 6);
            s = (m < 3'h4) ? 2'h1 : ((m < 3'h6) ? 2'h2 : 2'h3);
            // Run flavour first, then the low-power target, then the entry strobe
            @(posedge clk);
            mode_req <= {2'h0, r};
            req_v <= 1'b1;
            periph_en <= 4'($random(seed));
            retain_cfg <= 3'($random(seed));
            @(posedge clk);
            mode_req <= m;
            @(posedge clk);
            req_v <= 1'b0;
            sleep_entry <= 1'b1;
            // The run target took effect on the edge just passed
            @(negedge clk);
            cmp_mode(cur_mode, {2'h0, r});
            cmp_out(outs, exp_out({2'h0, r}));
            @(posedge clk);
            sleep_entry <= 1'b0;
            mode_req <= 3'h0;
            req_v <= 1'b1;
            want <= 3'h1 << (s % 3);
            @(negedge clk);
            cmp_mode(cur_mode, m);
            cmp_out(outs, exp_out(m));
            repeat (6) @(posedge clk);
            req_v <= 1'b0;
            want <= 3'h1 << (s - 1);
            ce <= !i[0];
            @(negedge clk);
            cmp_mode(cur_mode, m);
            if (i[0]) begin
                // With the clock enable low the wake must not get through
                repeat (5) @(posedge clk);
                ce <= 1'b1;
                @(negedge clk);
                cmp_mode(cur_mode, m);
            end
            k = 0;
            while (wake_pulse !== 1'b1 && k < 10) begin
                @(negedge clk);
                k++;
            end
            if (k == 10) begin
                errors++;
                $display("wrong value at %0t: no wake pulse", $time);
            end
            cmp_mode(cur_mode, {2'h0, r});
            cmp_mode({1'b0, wake_src}, {1'b0, s});
            cmp_out(outs, exp_out({2'h0, r}));
            @(posedge clk);
            want <= 3'h0;
            // The wake pulse lasts one cycle only
            @(negedge clk);
            cmp_mode({2'h0, wake_pulse}, 3'h0);
            repeat (4) @(posedge clk);
        end
        end_sim;
    end
    // Watchdog against a hang
    initial begin
        #5000;
        errors++;
        end_sim;
    end
endmodule // power_mode_wake_control_tb_top
`default_nettype wire
